// >>> hw/hwdt_pkg.sv
// constants shared by the hardware watchdog design files
// assumes one system clock at the rate below and an 8-bit special function bus
package hwdt_pkg;
	localparam int unsigned HWDT_CLK_PERIOD_NS = 8;
	localparam int unsigned HWDT_COUNT_W = 14;
	localparam logic [13:0] HWDT_COUNT_RESET = 14'h0000;
	localparam logic [13:0] HWDT_COUNT_LAST = 14'h3fff;
	localparam int unsigned HWDT_PERIPH_DIV = 12;
	localparam logic [3:0] HWDT_PHASE_RESET = 4'h0;
	localparam logic [3:0] HWDT_PHASE_LAST = 4'(HWDT_PERIPH_DIV - 1);
	localparam logic [7:0] HWDT_RESTART_ADDR = 8'ha6;
	localparam logic [7:0] HWDT_UNLOCK_FIRST = 8'h1e;
	localparam logic [7:0] HWDT_UNLOCK_SECOND = 8'he1;
	localparam logic [7:0] HWDT_READ_VALUE = 8'hff;
	localparam logic [7:0] HWDT_RDATA_RESET = 8'h00;
	// least length of the internal reset pulse raised on overflow
	localparam int unsigned HWDT_INT_RESET_NS = 200;
	localparam int unsigned HWDT_INT_RESET_CYC =
		(HWDT_INT_RESET_NS + HWDT_CLK_PERIOD_NS - 1) / HWDT_CLK_PERIOD_NS;
	localparam logic [7:0] HWDT_INT_RESET_CYC_W = 8'(HWDT_INT_RESET_CYC);
	typedef enum logic [0:0] {HWDT_PWR_RUN, HWDT_PWR_DOWN} hwdt_pwr_t;
endpackage

// >>> hw/hwdt_prescale.sv
// peripheral cycle generator: one tick every twelve system clocks
// assumes run is low while the phase clocks are stopped
`timescale 1ns/1ns
module hwdt_prescale
	import hwdt_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic soft_clear, // synchronous clear from internal reset
	input wire logic run, // phase clocks running
	output logic tick // one-cycle peripheral cycle pulse
);
	logic [3:0] phase;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase <= HWDT_PHASE_RESET;
		end else if (soft_clear) begin
			phase <= HWDT_PHASE_RESET;
		end else if (run) begin
			if (phase == HWDT_PHASE_LAST) begin
				phase <= HWDT_PHASE_RESET;
			end else begin
				phase <= phase + 4'h1;
			end
		end
	end

	// phase is held in powerdown, so the partial peripheral cycle resumes too
	assign tick = run && (phase == HWDT_PHASE_LAST);
endmodule

// >>> hw/hwdt_unlock.sv
// two-byte restart sequence detector for the restart register
// assumes wr is a one-cycle strobe already decoded to the restart address
`timescale 1ns/1ns
module hwdt_unlock
	import hwdt_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic soft_clear, // synchronous clear from internal reset
	input wire logic wr, // write to restart register
	input wire logic [7:0] wdata, // written byte
	output logic restart // one-cycle restart pulse
);
	logic armed;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (soft_clear) begin
			armed <= 1'b0;
		end else if (wr) begin
			// any byte other than the first one abandons a partial sequence
			armed <= (wdata == HWDT_UNLOCK_FIRST);
		end
	end

	assign restart = wr && armed && (wdata == HWDT_UNLOCK_SECOND);
endmodule

// >>> hw/hwdt_top.sv
// hardware watchdog: restart register on the special function bus,
// 14-bit peripheral cycle counter, internal reset on overflow, power modes
// assumes the sfr strobes are synchronous to clk_sys and last one cycle;
// the external interrupt pins are asynchronous and active low
`timescale 1ns/1ns
module hwdt_top
	import hwdt_pkg::*;
#(
	parameter int unsigned INT_RESET_CYCLES = HWDT_INT_RESET_CYC,
	parameter int unsigned COUNT_W = HWDT_COUNT_W // at most 14; narrower only for short runs
)
(
	input wire logic clk_sys, // system clock, 125 MHz
	input wire logic rst_n, // external device reset, asynchronous, active low
	input wire logic [7:0] sfr_addr, // special function address
	input wire logic sfr_wr, // one-cycle write strobe
	input wire logic sfr_rd, // one-cycle read strobe
	input wire logic [7:0] sfr_wdata, // write data
	output logic [7:0] sfr_rdata, // read data, valid the cycle after sfr_rd
	output logic sfr_rhit, // read answered by this block, one cycle
	input wire logic idle_mode, // device in idle mode
	input wire logic powerdown_enter, // one-cycle request to enter powerdown
	input wire logic external_interrupt_zero_n, // wake pin 0, active low
	input wire logic external_interrupt_one_n, // wake pin 1, active low
	output logic powerdown_active, // phase clocks stopped
	output logic wake_pulse, // one-cycle pulse when an interrupt ends powerdown
	output logic internal_reset_n, // internal device reset, active low
	output logic watchdog_overflow, // one-cycle overflow pulse
	output logic watchdog_enabled, // watchdog counting state
	output logic watchdog_caused_reset // sticky until external reset
);
	hwdt_pwr_t pwr_state;
	hwdt_pwr_t next_pwr_state;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = COUNT_W'(HWDT_COUNT_RESET);
	localparam logic [COUNT_W-1:0] COUNT_LAST = COUNT_W'(HWDT_COUNT_LAST);
	logic [COUNT_W-1:0] hardware_watchdog_counter;
	logic [7:0] reset_cnt;
	logic int_reset;
	logic tick;
	logic restart;
	logic restart_wr;
	logic external_interrupt_zero_meta;
	logic external_interrupt_zero_sync;
	logic external_interrupt_one_meta;
	logic external_interrupt_one_sync;
	logic wake;
	logic run;
	logic overflow;

	function automatic logic hit_restart(input logic [7:0] addr);
		hit_restart = (addr == HWDT_RESTART_ADDR);
	endfunction

	// pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			external_interrupt_zero_meta <= 1'b1;
			external_interrupt_zero_sync <= 1'b1;
			external_interrupt_one_meta <= 1'b1;
			external_interrupt_one_sync <= 1'b1;
		end else begin
			external_interrupt_zero_meta <= external_interrupt_zero_n;
			external_interrupt_zero_sync <= external_interrupt_zero_meta;
			external_interrupt_one_meta <= external_interrupt_one_n;
			external_interrupt_one_sync <= external_interrupt_one_meta;
		end
	end

	assign wake = !external_interrupt_zero_sync || !external_interrupt_one_sync;

	always_comb begin
		next_pwr_state = pwr_state;
		case (pwr_state)
			HWDT_PWR_RUN: begin
				if (powerdown_enter) begin
					next_pwr_state = HWDT_PWR_DOWN;
				end
			end
			HWDT_PWR_DOWN: begin
				if (wake) begin
					next_pwr_state = HWDT_PWR_RUN;
				end
			end
			default: begin
				next_pwr_state = HWDT_PWR_RUN;
			end
		endcase
	end

	// a reset of either kind ends powerdown back in the run state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwr_state <= HWDT_PWR_RUN;
		end else if (int_reset) begin
			pwr_state <= HWDT_PWR_RUN;
		end else begin
			pwr_state <= next_pwr_state;
		end
	end

	assign powerdown_active = (pwr_state == HWDT_PWR_DOWN);
	assign wake_pulse = (pwr_state == HWDT_PWR_DOWN) && wake;
	// idle leaves the phase clocks running, so it does not appear here
	assign run = (pwr_state == HWDT_PWR_RUN);

	assign restart_wr = sfr_wr && hit_restart(sfr_addr);

	hwdt_prescale u_prescale (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.soft_clear(int_reset),
		.run(run),
		.tick(tick)
	);

	hwdt_unlock u_unlock (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.soft_clear(int_reset),
		.wr(restart_wr),
		.wdata(sfr_wdata),
		.restart(restart)
	);

	assign overflow = watchdog_enabled && tick
		&& (hardware_watchdog_counter == COUNT_LAST);

	// the count has no load path from the bus; restart, overflow and the internal reset clear it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hardware_watchdog_counter <= COUNT_ZERO;
		end else if (int_reset || overflow) begin
			hardware_watchdog_counter <= COUNT_ZERO;
		end else if (restart) begin
			hardware_watchdog_counter <= COUNT_ZERO;
		end else if (watchdog_enabled && tick) begin
			hardware_watchdog_counter <= hardware_watchdog_counter + COUNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_enabled <= 1'b0;
		end else if (int_reset || overflow) begin
			// dropped at once, so the overflow pulse never shows a counting watchdog
			watchdog_enabled <= 1'b0;
		end else if (restart) begin
			watchdog_enabled <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_overflow <= 1'b0;
		end else begin
			watchdog_overflow <= overflow;
		end
	end

	// stretched so that every block on the internal reset sees it cleanly;
	// only internal_reset_n leaves the block, the reset pin is never driven
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reset_cnt <= 8'h00;
		end else if (overflow) begin
			reset_cnt <= 8'(INT_RESET_CYCLES);
		end else if (reset_cnt != 8'h00) begin
			reset_cnt <= reset_cnt - 8'h01;
		end
	end

	assign int_reset = (reset_cnt != 8'h00);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			internal_reset_n <= 1'b0;
		end else begin
			internal_reset_n <= !overflow && !int_reset;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_caused_reset <= 1'b0;
		end else if (overflow) begin
			watchdog_caused_reset <= 1'b1;
		end
	end

	// reads of the restart address are answered with a constant and touch nothing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= HWDT_RDATA_RESET;
			sfr_rhit <= 1'b0;
		end else if (sfr_rd && hit_restart(sfr_addr)) begin
			sfr_rdata <= HWDT_READ_VALUE;
			sfr_rhit <= 1'b1;
		end else begin
			sfr_rdata <= HWDT_RDATA_RESET;
			sfr_rhit <= 1'b0;
		end
	end
endmodule

// >>> verif/hwdt_top_monitor.sv
// assertions on the watchdog top ports
// assumes a bind from the bench passing the internal reset length
`timescale 1ns/1ns
module hwdt_top_monitor
	import hwdt_pkg::*;
#(
	parameter int unsigned INT_RESET_CYCLES = HWDT_INT_RESET_CYC
)
(
	input wire logic clk_sys, // clock
	input wire logic rst_n, // reset
	input wire logic [7:0] sfr_addr, // address
	input wire logic sfr_wr, // write
	input wire logic sfr_rd, // read
	input wire logic [7:0] sfr_wdata, // write data
	input wire logic [7:0] sfr_rdata, // read data
	input wire logic sfr_rhit, // read hit
	input wire logic powerdown_enter, // enter request
	input wire logic powerdown_active, // stopped
	input wire logic wake_pulse, // wake
	input wire logic internal_reset_n, // internal reset
	input wire logic watchdog_overflow, // overflow
	input wire logic watchdog_enabled, // counting
	input wire logic watchdog_caused_reset // sticky cause
);
	localparam int LOW_M1 = INT_RESET_CYCLES;
	logic armed;
	wire logic hit_w = sfr_wr && sfr_addr == HWDT_RESTART_ADDR;
	wire logic rhit_w = sfr_rd && sfr_addr == HWDT_RESTART_ADDR;
	wire logic go_w = hit_w && sfr_wdata == HWDT_UNLOCK_SECOND && armed && internal_reset_n;
	// writes elsewhere leave the partial sequence alone
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (!internal_reset_n) begin
			armed <= 1'b0;
		end else if (hit_w) begin
			armed <= sfr_wdata == HWDT_UNLOCK_FIRST;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	read_answer_a: assert property (rhit_w && internal_reset_n |=>
		sfr_rhit && sfr_rdata == HWDT_READ_VALUE) else $error("read answer wrong");
	read_quiet_a: assert property (!rhit_w |=>
		!sfr_rhit && sfr_rdata == HWDT_RDATA_RESET) else $error("spurious read answer");
	restart_enables_a: assert property (go_w |=> watchdog_enabled)
		else $error("restart did not enable");
	stray_blocked_a: assert property (!watchdog_enabled && !go_w |=> !watchdog_enabled)
		else $error("enabled without sequence");
	overflow_reset_a: assert property (watchdog_overflow |->
		$fell(internal_reset_n) && !watchdog_enabled) else $error("overflow without reset");
	reset_length_a: assert property ($fell(internal_reset_n) |->
		##LOW_M1 !internal_reset_n ##1 internal_reset_n) else $error("reset length wrong");
	cause_sticky_a: assert property (watchdog_overflow |=>
		watchdog_caused_reset ##1 watchdog_caused_reset) else $error("cause not held");
	disabled_quiet_a: assert property (!watchdog_enabled |=> !watchdog_overflow)
		else $error("overflow while disabled");
	frozen_a: assert property (powerdown_active |-> !watchdog_overflow)
		else $error("overflow in powerdown");
	enter_pd_a: assert property (powerdown_enter && internal_reset_n |=> powerdown_active)
		else $error("powerdown not entered");
	wake_a: assert property (wake_pulse |=> !powerdown_active)
		else $error("wake did not end powerdown");
endmodule

// >>> verif/hwdt_top_tb.sv
// self-checking bench for the hardware watchdog top
// assumes package, design and monitor files compiled first
`timescale 1ns/1ns
module hwdt_top_tb;
	import hwdt_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, a, sfr_rdata;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, idle_mode = 1'b0, pd_req = 1'b0;
	logic [1:0] wake_n = 2'b11;
	logic sfr_rhit, pd_act, wake_pulse, irst_n, ovf, en, caused;
	int n_mismatch = 0, n_compared = 0, cyc = 0, n, p;
	int exp_en = 0; // model of the counting state
	int n_run = 0, base = 0; // running cycles, counted at the falling edge
	// a narrow counter keeps the overflow run short; the bounds follow
	localparam int CNT_W = 6;
	localparam int OVF_LO = HWDT_PERIPH_DIV * ((1 << CNT_W) - 1) + 1;
	localparam int OVF_HI = HWDT_PERIPH_DIV * (1 << CNT_W);
	logic [7:0] seq[$]; // model: bytes written to the restart register
	always #4 clk_sys = ~clk_sys;
	// only cycles with the phase clocks running move the watchdog
	always @(negedge clk_sys) begin
		if (rst_n && !pd_act) begin
			n_run++;
		end
	end
	hwdt_top #(.INT_RESET_CYCLES(2), .COUNT_W(CNT_W)) hwdt_top_i (.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_rhit(sfr_rhit), .idle_mode(idle_mode),
		.powerdown_enter(pd_req), .external_interrupt_zero_n(wake_n[0]),
		.external_interrupt_one_n(wake_n[1]), .powerdown_active(pd_act),
		.wake_pulse(wake_pulse), .internal_reset_n(irst_n), .watchdog_overflow(ovf),
		.watchdog_enabled(en), .watchdog_caused_reset(caused));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_in(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		tick(1);
		sfr_addr = ad;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
		sfr_addr = ~ad;
		sfr_wdata = ~d;
		if (ad == HWDT_RESTART_ADDR) begin
			if (d == HWDT_UNLOCK_SECOND && seq.size() > 0 && seq[$] == HWDT_UNLOCK_FIRST)
				exp_en = 1;
			seq.push_back(d);
		end
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		tick(1);
		sfr_addr = ad;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
		chk(8'(sfr_rhit), 8'(exp == HWDT_READ_VALUE));
	endtask
	task automatic pd_enter(input bit rs);
		if (rs) begin
			wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_FIRST);
			wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_SECOND);
		end
		pd_req = 1'b1;
		tick(1);
		pd_req = 1'b0;
		chk(8'(pd_act), 8'h01);
		tick(300);
		chk(8'({pd_act, ovf}), 8'h02);
	endtask
	task automatic wake_up(input int p);
		wake_n[p] = 1'b0;
		n = 0;
		while (wake_pulse !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		chk(8'(wake_pulse), 8'h01);
		tick(1);
		wake_n[p] = 1'b1;
		chk(8'({pd_act, en}), 8'(exp_en));
		// the synchronised pin stays low two more edges; an entry now would wake at once
		tick(3);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ceiling covers one short overflow period, four powerdowns and the bus tests
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(57));
		tick(4);
		rst_n = 1'b1;
		tick(2);
		chk(8'({irst_n, en, caused, pd_act}), 8'h08);
		a = 8'($urandom);
		if (a == HWDT_RESTART_ADDR)
			a = 8'ha5;
		rd(HWDT_RESTART_ADDR, HWDT_READ_VALUE);
		rd(a, HWDT_RDATA_RESET);
		$display("test reads done");
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_SECOND);
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_FIRST);
		wr(HWDT_RESTART_ADDR, 8'($urandom));
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_SECOND);
		chk(8'(en), 8'(exp_en));
		$display("test stray sequence done");
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_FIRST);
		wr(a, 8'($urandom));
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_SECOND);
		chk(8'(en), 8'(exp_en));
		$display("test restart done");
		for (p = 0; p < 2; p++) begin
			pd_enter(1'b1);
			wake_up(p);
		end
		$display("test powerdown wake done");
		pd_enter(1'b1);
		rst_n = 1'b0;
		exp_en = 0;
		seq.delete();
		tick(4);
		rst_n = 1'b1;
		tick(2);
		chk(8'({pd_act, en}), 8'(exp_en));
		$display("test powerdown reset done");
		idle_mode = 1'b1;
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_FIRST);
		wr(HWDT_RESTART_ADDR, HWDT_UNLOCK_SECOND);
		base = n_run;
		tick(200);
		// no restart before this entry: the held count has to carry across the wake
		pd_enter(1'b0);
		wake_up(0);
		n = 0;
		while (ovf !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		chk_in(n_run - base, OVF_LO, OVF_HI);
		chk(8'({irst_n, en}), 8'h00);
		tick(6);
		chk(8'({irst_n, en, caused}), 8'h05);
		$display("test idle overflow done");
		end_sim();
	end
endmodule
bind hwdt_top hwdt_top_monitor #(.INT_RESET_CYCLES(INT_RESET_CYCLES)) hwdt_top_monitor_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rhit(sfr_rhit),
	.powerdown_enter(powerdown_enter), .powerdown_active(powerdown_active),
	.wake_pulse(wake_pulse), .internal_reset_n(internal_reset_n),
	.watchdog_overflow(watchdog_overflow), .watchdog_enabled(watchdog_enabled),
	.watchdog_caused_reset(watchdog_caused_reset));
